// ### hdl/frsp_params.svh
`ifndef FRSP_PARAMS_SVH
`define FRSP_PARAMS_SVH

// Clock period of clk_in in ns (50 MHz)
`define FRSP_CLK_NS 20
// Least time to whole cycles, rounded up
`define FRSP_MIN_CYC(ns) (((ns) + `FRSP_CLK_NS - 1) / `FRSP_CLK_NS)

// Pin widths
`define FRSP_AW 21
`define FRSP_DW 16
`define FRSP_CW 11

// Status bit positions on the data bus
`define FRSP_TOGGLE_BIT 6
`define FRSP_SUSP_TOGGLE_BIT 2

// Times as printed, in ns
`define FRSP_T_READY_BUSY_NS 20000
`define FRSP_T_READY_IDLE_NS 500
`define FRSP_T_RP_NS 500
`define FRSP_T_RH_NS 50
`define FRSP_T_RPD_NS 20000
`define FRSP_T_BUSY_NS 90
`define FRSP_T_ASO_NS 15
`define FRSP_T_OEPH_NS 20
`define FRSP_T_ACC_NS 70
`define FRSP_T_WP_NS 30
`define FRSP_T_WPH_NS 30

// Derived cycle counts
`define FRSP_READY_BUSY_CYC `FRSP_MIN_CYC(`FRSP_T_READY_BUSY_NS)
`define FRSP_READY_IDLE_CYC `FRSP_MIN_CYC(`FRSP_T_READY_IDLE_NS)
`define FRSP_RP_CYC `FRSP_MIN_CYC(`FRSP_T_RP_NS)
`define FRSP_RH_CYC `FRSP_MIN_CYC(`FRSP_T_RH_NS)
`define FRSP_RPD_CYC `FRSP_MIN_CYC(`FRSP_T_RPD_NS)
`define FRSP_BUSY_CYC `FRSP_MIN_CYC(`FRSP_T_BUSY_NS)
`define FRSP_ASO_CYC `FRSP_MIN_CYC(`FRSP_T_ASO_NS)
`define FRSP_OEPH_CYC `FRSP_MIN_CYC(`FRSP_T_OEPH_NS)
`define FRSP_WP_CYC `FRSP_MIN_CYC(`FRSP_T_WP_NS)
`define FRSP_WPH_CYC `FRSP_MIN_CYC(`FRSP_T_WPH_NS)
// Output enable low long enough for access plus the two sync stages
`define FRSP_RD_CYC (`FRSP_MIN_CYC(`FRSP_T_ACC_NS) + 2)

`endif

// ### hdl/frsp_pkg.sv
package frsp_pkg;

    // Commands accepted on the user port
    typedef enum logic [2:0] {
        FRSP_OP_READ = 3'h0,
        FRSP_OP_WRITE = 3'h1,
        FRSP_OP_WRITE_LAST = 3'h2,
        FRSP_OP_POLL = 3'h3,
        FRSP_OP_RESET = 3'h4,
        FRSP_OP_STANDBY = 3'h5
    } frsp_op_e;

    // Sequencer states, one-hot
    typedef enum logic [9:0] {
        FRSP_IDLE = 10'h001,
        FRSP_RST_LOW = 10'h002,
        FRSP_RST_WAIT = 10'h004,
        FRSP_RST_HIGH = 10'h008,
        FRSP_RD_ADDR = 10'h010,
        FRSP_RD_OE = 10'h020,
        FRSP_RD_GAP = 10'h040,
        FRSP_WR_PULSE = 10'h080,
        FRSP_WR_HIGH = 10'h100,
        FRSP_BUSY_WAIT = 10'h200
    } frsp_state_e;

    // Flash pins driven by the host
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
    } frsp_pins_s;

    // Whole state of the host sequencer
    typedef struct packed {
        frsp_state_e state;
        frsp_op_e op;
        logic [10:0] cnt;
        logic [15:0] rdata;
        logic prev_toggle;
        logic have_prev;
        logic was_busy;
        logic rsp_valid;
        frsp_pins_s pins;
    } frsp_host_s;

endpackage : frsp_pkg

// ### hdl/frsp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser bank for pins driven by the asynchronous flash
module frsp_sync #(
    parameter int W = 17
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    // Pin side and synchronised side
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // The first stage feeds only the second; resets to all ones (idle bus)
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= '1;
            sync_r <= '1;
        end else if (en_in) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : frsp_sync

`default_nettype wire

// ### hdl/frsp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "frsp_params.svh"

// How it works
// - After reset goes high, wait at least 50 ns before a read.
// - Standby through reset: hold reset low at least 20 us.
// - Each status read is bounded by a chip select and output enable pulse.
// - Address stands at least 15 ns before output enable falls.
// - Output enable stays high at least 20 ns between status reads.
module frsp_host
    import frsp_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    // User command port
    input wire logic cmd_valid_in,
    input wire frsp_op_e cmd_op_in,
    input wire logic [`FRSP_AW-1:0] cmd_addr_in,
    input wire logic [`FRSP_DW-1:0] cmd_data_in,
    output logic cmd_ready_out,
    // User response port
    output logic rsp_valid_out,
    output logic [`FRSP_DW-1:0] rsp_data_out,
    output logic dev_busy_out,
    // Flash pins
    output logic [`FRSP_AW-1:0] flash_addr_out,
    input wire logic [`FRSP_DW-1:0] flash_dq_in,
    output logic [`FRSP_DW-1:0] flash_dq_out,
    output logic flash_dq_oe_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    output logic flash_reset_n_out,
    input wire logic ready_busy_n_in
);
    localparam logic [10:0] RD_CYC = 11'(`FRSP_RD_CYC);
    localparam logic [10:0] ASO_CYC = 11'(`FRSP_ASO_CYC);
    localparam logic [10:0] OEPH_CYC = 11'(`FRSP_OEPH_CYC);
    localparam logic [10:0] WP_CYC = 11'(`FRSP_WP_CYC);
    localparam logic [10:0] WPH_CYC = 11'(`FRSP_WPH_CYC);
    localparam logic [10:0] BUSY_CYC = 11'(`FRSP_BUSY_CYC);
    localparam logic [10:0] RP_CYC = 11'(`FRSP_RP_CYC);
    localparam logic [10:0] RPD_CYC = 11'(`FRSP_RPD_CYC);
    localparam logic [10:0] RH_CYC = 11'(`FRSP_RH_CYC);
    localparam logic [10:0] RDY_BUSY_CYC = 11'(`FRSP_READY_BUSY_CYC);
    localparam logic [10:0] RDY_IDLE_CYC = 11'(`FRSP_READY_IDLE_CYC);

    frsp_host_s st_r;
    frsp_host_s st_nxt;
    logic [`FRSP_DW:0] pin_sync;
    logic [`FRSP_DW-1:0] dq_sync;
    logic rb_n_sync;
    logic cnt_done;

    // Flash data and ready_busy_n come from a clockless part
    frsp_sync #(
        .W(`FRSP_DW + 1)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .en_in(en_in),
        .async_in({ready_busy_n_in, flash_dq_in}),
        .sync_out(pin_sync)
    );

    assign dq_sync = pin_sync[`FRSP_DW-1:0];
    assign rb_n_sync = pin_sync[`FRSP_DW];
    assign cnt_done = (st_r.cnt <= 11'h001);

    // Next-state logic for the whole sequencer
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp_valid = 1'b0;
        if (!cnt_done) begin
            st_nxt.cnt = st_r.cnt - 11'h001;
        end
        case (st_r.state)
            FRSP_IDLE: begin
                st_nxt.pins.ce_n = 1'b1;
                st_nxt.pins.oe_n = 1'b1;
                st_nxt.pins.we_n = 1'b1;
                st_nxt.pins.dq_oe = 1'b0;
                if (cmd_valid_in) begin
                    st_nxt.op = cmd_op_in;
                    st_nxt.pins.addr = cmd_addr_in;
                    st_nxt.have_prev = 1'b0;
                    case (cmd_op_in)
                        FRSP_OP_RESET, FRSP_OP_STANDBY: begin
                            st_nxt.state = FRSP_RST_LOW;
                            st_nxt.pins.reset_n = 1'b0;
                            st_nxt.was_busy = ~rb_n_sync;
                            // Standby needs the long low time
                            st_nxt.cnt = (cmd_op_in == FRSP_OP_STANDBY) ?
                                RPD_CYC : RP_CYC;
                        end
                        FRSP_OP_WRITE, FRSP_OP_WRITE_LAST: begin
                            // Address setup is zero for writes
                            st_nxt.state = FRSP_WR_PULSE;
                            st_nxt.pins.dq = cmd_data_in;
                            st_nxt.pins.dq_oe = 1'b1;
                            st_nxt.pins.ce_n = 1'b0;
                            st_nxt.pins.we_n = 1'b0;
                            st_nxt.cnt = WP_CYC;
                        end
                        default: begin
                            st_nxt.state = FRSP_RD_ADDR;
                            st_nxt.pins.ce_n = 1'b0;
                            st_nxt.cnt = ASO_CYC;
                        end
                    endcase
                end
            end
            FRSP_RST_LOW: begin
                if (cnt_done) begin
                    st_nxt.state = FRSP_RST_WAIT;
                    st_nxt.pins.reset_n = 1'b1;
                    // Busy part needs the long abort time
                    st_nxt.cnt = st_r.was_busy ?
                        RDY_BUSY_CYC : RDY_IDLE_CYC;
                end
            end
            FRSP_RST_WAIT: begin
                if (cnt_done) begin
                    st_nxt.state = FRSP_RST_HIGH;
                    st_nxt.cnt = RH_CYC;
                end
            end
            FRSP_RST_HIGH: begin
                if (cnt_done) begin
                    st_nxt.state = FRSP_IDLE;
                    st_nxt.rsp_valid = 1'b1;
                end
            end
            FRSP_RD_ADDR: begin
                // Address already stable for the setup time
                if (cnt_done) begin
                    st_nxt.state = FRSP_RD_OE;
                    st_nxt.pins.oe_n = 1'b0;
                    st_nxt.cnt = RD_CYC;
                end
            end
            FRSP_RD_OE: begin
                if (cnt_done) begin
                    st_nxt.rdata = dq_sync;
                    st_nxt.pins.oe_n = 1'b1;
                    st_nxt.pins.ce_n = 1'b1;
                    st_nxt.prev_toggle = dq_sync[`FRSP_TOGGLE_BIT];
                    st_nxt.have_prev = 1'b1;
                    if (st_r.op != FRSP_OP_POLL) begin
                        // Next command may follow at once
                        st_nxt.state = FRSP_IDLE;
                        st_nxt.rsp_valid = 1'b1;
                    end else if (st_r.have_prev && (st_r.prev_toggle ==
                            dq_sync[`FRSP_TOGGLE_BIT])) begin
                        st_nxt.state = FRSP_IDLE;
                        st_nxt.rsp_valid = 1'b1;
                    end else begin
                        st_nxt.state = FRSP_RD_GAP;
                        st_nxt.cnt = OEPH_CYC;
                    end
                end
            end
            FRSP_RD_GAP: begin
                // Output enable high between status reads
                if (cnt_done) begin
                    st_nxt.state = FRSP_RD_ADDR;
                    st_nxt.pins.ce_n = 1'b0;
                    st_nxt.cnt = ASO_CYC;
                end
            end
            FRSP_WR_PULSE: begin
                if (cnt_done) begin
                    st_nxt.state = FRSP_WR_HIGH;
                    st_nxt.pins.we_n = 1'b1;
                    st_nxt.cnt = WPH_CYC;
                end
            end
            FRSP_WR_HIGH: begin
                if (cnt_done) begin
                    st_nxt.pins.ce_n = 1'b1;
                    st_nxt.pins.dq_oe = 1'b0;
                    if (st_r.op == FRSP_OP_WRITE_LAST) begin
                        // Busy flag is not valid until this passes
                        st_nxt.state = FRSP_BUSY_WAIT;
                        st_nxt.cnt = BUSY_CYC + 11'h002;
                    end else begin
                        st_nxt.state = FRSP_IDLE;
                        st_nxt.rsp_valid = 1'b1;
                    end
                end
            end
            FRSP_BUSY_WAIT: begin
                if (cnt_done) begin
                    st_nxt.state = FRSP_IDLE;
                    st_nxt.rsp_valid = 1'b1;
                end
            end
            default: begin
                st_nxt.state = FRSP_IDLE;
            end
        endcase
    end

    // State register; enable freezes everything
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r.state <= FRSP_IDLE;
            st_r.op <= FRSP_OP_READ;
            st_r.cnt <= 11'h000;
            st_r.rdata <= 16'h0000;
            st_r.prev_toggle <= 1'b0;
            st_r.have_prev <= 1'b0;
            st_r.was_busy <= 1'b0;
            st_r.rsp_valid <= 1'b0;
            st_r.pins.addr <= 21'h00_0000;
            st_r.pins.dq <= 16'h0000;
            st_r.pins.dq_oe <= 1'b0;
            st_r.pins.ce_n <= 1'b1;
            st_r.pins.oe_n <= 1'b1;
            st_r.pins.we_n <= 1'b1;
            st_r.pins.reset_n <= 1'b1;
        end else if (en_in) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, except dev_busy_out from the synchroniser
    assign cmd_ready_out = (st_r.state == FRSP_IDLE);
    assign rsp_valid_out = st_r.rsp_valid;
    assign rsp_data_out = st_r.rdata;
    assign dev_busy_out = ~rb_n_sync;
    assign flash_addr_out = st_r.pins.addr;
    assign flash_dq_out = st_r.pins.dq;
    assign flash_dq_oe_out = st_r.pins.dq_oe;
    assign flash_ce_n_out = st_r.pins.ce_n;
    assign flash_oe_n_out = st_r.pins.oe_n;
    assign flash_we_n_out = st_r.pins.we_n;
    assign flash_reset_n_out = st_r.pins.reset_n;
endmodule : frsp_host

`default_nettype wire

// ### testbench/frsp_host_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Pin timing the host must keep toward the flash
module frsp_host_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Flash pins
    input wire logic [20:0] flash_addr_out,
    input wire logic flash_dq_oe_out,
    input wire logic flash_ce_n_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_reset_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic [10:0] low_cnt_r;

    // Length of the running reset pulse; saturates so it never wraps
    always_ff @(posedge clk_in) begin
        if (rst_in || flash_reset_n_out) begin
            low_cnt_r <= 11'h000;
        end else if (low_cnt_r != 11'h7ff) begin
            low_cnt_r <= low_cnt_r + 11'h001;
        end
    end

    // Steps of a reset and of a read
    sequence s_rst_release;
        $rose(flash_reset_n_out);
    endsequence
    sequence s_read_start;
        $fell(flash_oe_n_out);
    endsequence

    a_rst_pulse_width: assert property (
        s_rst_release |-> low_cnt_r >= 11'h019)
        else $error("reset pulse shorter than 25 cycles");
    a_read_after_rst: assert property (
        s_rst_release |-> (flash_oe_n_out && flash_ce_n_out) [*3])
        else $error("read started too soon after reset release");
    a_addr_before_oe: assert property (
        s_read_start |-> flash_addr_out == $past(flash_addr_out))
        else $error("address moved as output enable fell");
    a_oe_high_gap: assert property (
        s_read_start |-> $past(flash_oe_n_out, 2))
        else $error("output enable high too briefly between reads");
    a_read_framed: assert property (
        $rose(flash_oe_n_out) |-> flash_ce_n_out)
        else $error("read not closed by chip select");
    a_bus_released: assert property (
        !flash_oe_n_out |-> !flash_dq_oe_out)
        else $error("host drives data bus during a read");
    a_quiet_in_rst: assert property (
        !flash_reset_n_out |-> flash_ce_n_out && flash_oe_n_out)
        else $error("access while flash reset is low");
endmodule : frsp_host_chk

bind frsp_host frsp_host_chk i_frsp_host_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flash_addr_out(flash_addr_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_oe_n_out(flash_oe_n_out),
    .flash_reset_n_out(flash_reset_n_out)
);

`default_nettype wire

// ### testbench/frsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural flash: array reads, one embedded operation, status bits
module frsp_flash_model #(
    parameter int BUSY_NS = 3000,
    parameter logic [15:0] START_CODE = 16'h0030,
    parameter logic [4:0] SUSP_SECTOR = 5'h01
) (
    // Host-driven pins
    input wire logic [20:0] addr_in,
    input wire logic [15:0] dq_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic reset_n_in,
    // Device-driven pins
    output logic [15:0] dq_out,
    output logic ready_busy_n_out
);
    logic busy = 1'b0;
    logic tog = 1'b0;
    logic susp;
    logic [15:0] val;
    realtime start_t = -1.0;
    realtime taken_t = -1.0;
    logic rd;

    assign rd = !ce_n_in && !oe_n_in && reset_n_in;
    assign susp = (addr_in[20:16] == SUSP_SECTOR);
    assign ready_busy_n_out = !busy;

    // Closing write arms the operation; writes need no turnaround
    always @(posedge we_n_in) begin
        if (!ce_n_in && reset_n_in && dq_in === START_CODE) begin
            start_t = $realtime + 40;
        end
    end

    // Only process that drives busy, so start and abort never race
    always #10 begin
        if (start_t != taken_t && $realtime >= start_t) begin
            taken_t = start_t;
            busy = 1'b1;
        end
        if (busy && ($realtime >= taken_t + BUSY_NS || !reset_n_in)) begin
            busy = 1'b0;
        end
    end

    // A new read flips the status bits, whichever strobe opened it
    always @(posedge rd) begin
        if (busy) tog = !tog;
    end

    // Released bus shows the inverse so a stale value never passes
    always @* begin
        if (busy) begin
            val = {9'h000, tog, 3'h0, susp && tog, 2'h0};
        end else begin
            val = addr_in[15:0] ^ 16'h5a5a;
        end
        dq_out = rd ? val : ~val;
    end
endmodule : frsp_flash_model

`default_nettype wire

// ### testbench/frsp_host_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Drives commands, notes expected answers and checks them as they appear
module frsp_host_tb
    import frsp_pkg::*;
;
    typedef struct {int t0; int min; bit cmp; logic [15:0] d;} frsp_exp_s;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid = 1'b0;
    frsp_op_e cmd_op = FRSP_OP_READ;
    logic [20:0] cmd_addr = 21'h0_0000;
    logic [15:0] cmd_data = 16'h0000;
    logic cmd_ready, rsp_valid, dev_busy, dq_oe, ce_n, oe_n, we_n;
    logic reset_n, ready_busy_n;
    logic [15:0] rsp_data, dq_host, dq_dev, dq_wire;
    logic [20:0] addr, a;
    logic [15:0] ax, wd;
    logic [31:0] lat, want;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    frsp_exp_s exp_q[$];
    frsp_exp_s e_m;

    // Data bus level from whichever side drives it
    assign dq_wire = dq_oe ? dq_host : dq_dev;

    frsp_host i_frsp_host (.clk_in(clk_in), .rst_in(rst_in), .en_in(1'b1),
        .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
        .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
        .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
        .dev_busy_out(dev_busy), .flash_addr_out(addr), .flash_dq_in(dq_wire),
        .flash_dq_out(dq_host), .flash_dq_oe_out(dq_oe), .flash_ce_n_out(ce_n),
        .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
        .flash_reset_n_out(reset_n), .ready_busy_n_in(ready_busy_n));

    frsp_flash_model i_frsp_flash_model (.addr_in(addr), .dq_in(dq_wire),
        .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(reset_n),
        .dq_out(dq_dev), .ready_busy_n_out(ready_busy_n));

    // 50 MHz clock and a cycle count for latencies
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // Valid stays up after the take so commands can run back to back
    task automatic send(input frsp_op_e op, input logic [20:0] ad,
        input logic [15:0] d, input int min, input bit cmp,
        input logic [15:0] want);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = ad;
        cmd_data = d;
        while (cmd_ready !== 1'b1) begin
            n++;
            if (n > 2000) begin
                num_errors++;
                conclude();
            end
            @(negedge clk_in);
        end
        exp_q.push_back('{cyc + 1, min, cmp, want});
        @(negedge clk_in);
    endtask : send

    // Drops the request and waits for every noted answer
    task automatic drain;
        int n;
        n = 0;
        cmd_valid = 1'b0;
        while (exp_q.size() != 0) begin
            n++;
            if (n > 3000) begin
                num_errors++;
                conclude();
            end
            @(negedge clk_in);
        end
    endtask : drain

    // Oldest note against each answer
    always @(negedge clk_in) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected_rsp", 32'h0000_0001, 32'h0000_0000);
            end else begin
                e_m = exp_q.pop_front();
                lat = 32'(cyc - e_m.t0 >= e_m.min);
                check("latency", lat, 32'h0000_0001);
                want = 32'(e_m.d);
                if (e_m.cmp) begin
                    check("rsp_data", 32'(rsp_data), want);
                end
            end
        end
    end

    initial begin
        void'($urandom(38029));
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        // Random reads, then a write followed at once by a read
        for (int i = 0; i < 4; i++) begin
            a = 21'($urandom);
            ax = a[15:0] ^ 16'h5a5a;
            send(FRSP_OP_READ, a, 16'h0000, 7, 1'b1, ax);
        end
        // Top bit set so this plain write never starts an operation
        wd = 16'($urandom) | 16'h8000;
        send(FRSP_OP_WRITE, a, wd, 4, 1'b0, 16'h0000);
        send(FRSP_OP_READ, a, 16'h0000, 7, 1'b1, ax);
        drain();
        // Embedded operation: status bits per sector, then poll to the end
        send(FRSP_OP_WRITE, 21'h0_0555, 16'h00aa, 4, 1'b0, 16'h0000);
        a = 21'h1_0000;
        send(FRSP_OP_WRITE_LAST, a, 16'h0030, 9, 1'b0, 16'h0000);
        send(FRSP_OP_READ, 21'h1_0004, 16'h0000, 7, 1'b1, 16'h0044);
        send(FRSP_OP_READ, 21'h1_0004, 16'h0000, 7, 1'b1, 16'h0000);
        send(FRSP_OP_READ, 21'h0_0004, 16'h0000, 7, 1'b1, 16'h0040);
        check("dev_busy", {31'h0, dev_busy}, 32'h0000_0001);
        a = 21'($urandom);
        ax = a[15:0] ^ 16'h5a5a;
        send(FRSP_OP_POLL, a, 16'h0000, 16, 1'b1, ax);
        drain();
        check("dev_busy", {31'h0, dev_busy}, 32'h0000_0000);
        // Reset while busy, reset while idle, then standby
        send(FRSP_OP_WRITE_LAST, 21'h0_0000, 16'h0030, 9, 1'b0, 16'h0000);
        send(FRSP_OP_RESET, a, 16'h0000, 1028, 1'b0, 16'h0000);
        send(FRSP_OP_READ, a, 16'h0000, 7, 1'b1, ax);
        send(FRSP_OP_RESET, a, 16'h0000, 53, 1'b0, 16'h0000);
        send(FRSP_OP_READ, a, 16'h0000, 7, 1'b1, ax);
        send(FRSP_OP_STANDBY, a, 16'h0000, 1000, 1'b0, 16'h0000);
        drain();
        conclude();
    end
endmodule : frsp_host_tb

`default_nettype wire
